// [design/bcr_defs.svh]
// Offsets, field positions, reset values and masks of the configuration bank
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define BCR_OFF_SLOT        8'hC8
`define BCR_OFF_TUNE0       8'hCC
`define BCR_OFF_TUNE1       8'hD0
`define BCR_OFF_TUNE2       8'hD4
`define BCR_OFF_PI_CMD      8'hD8
`define BCR_OFF_PI_DATA     8'hDC
`define BCR_OFF_XLAT0       8'hE0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BCR_TUNE0_RST       32'h0400_1060
`define BCR_TUNE1_RST       32'h0000_0000
`define BCR_TUNE2_RST       32'h0019_0254
`define BCR_PI_DATA_RST     32'h0000_0000
`define BCR_XLAT0_RST       32'h0000_0000
`define BCR_PI_ADDR_RST     6'h00

// ----------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------
`define BCR_TUNE0_WMASK     32'hFFFF_1FFF
`define BCR_TUNE1_WMASK     32'hFFFF_03FF
`define BCR_TUNE2_WMASK     32'h007F_7FFF
`define BCR_PI_DATA_WMASK   32'hFFFF_FFFF
`define BCR_PI_ADDR_WMASK   32'h00FC_0000
`define BCR_XLAT0_FIXED     12'h000

// ----------------------------------------------------------------
// Product-data capability fields
// ----------------------------------------------------------------
`define BCR_PI_CAP_ID       8'h03
`define BCR_PI_NEXT_PTR     8'hF0
`define BCR_PI_ADDR_LSB     18
`define BCR_PI_ADDR_MSB     23
`define BCR_PI_OP_BIT       31
`define BCR_PI_EE_OFFSET    9'h040
`define BCR_SLOT_LSB        16

`endif

// [design/bcr_pkg.sv]
// Types shared by the configuration bank and its product-data sequencer
package bcr_pkg;

  // Slot event and state flags from the hot-plug logic
  typedef struct packed {
    logic presence_state;
    logic retention_latch_state;
    logic cmd_completed;
    logic presence_changed;
    logic retention_latch_changed;
    logic power_fault;
    logic button_pressed;
  } bcr_slot_s;

  // Link tuning values handed to the physical layer
  typedef struct packed {
    logic        hot_reset_en;
    logic        loopback_en;
    logic        crosslink_en;
    logic        force_config;
    logic        debug_sel;
    logic [2:0]  lane_neg_tries;
    logic [4:0]  ts1_count;
    logic [15:0] l1_entry_timer;
    logic [9:0]  l0s_lifetime;
    logic [15:0] l1_lifetime;
    logic [7:0]  clock_recovery_fts;
    logic [6:0]  l0s_exit_latency;
    logic [6:0]  l1_exit_latency;
  } bcr_tune_s;

  // Access toward the product_info_store EEPROM controller
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [8:0]  addr;
    logic [31:0] wdata;
  } bcr_ee_req_s;

endpackage : bcr_pkg

// [design/bcr_pi_seq.sv]
// Sequencer for one product_info_store EEPROM access
`timescale 1ns/1ps
`include "bcr_defs.svh"

module bcr_pi_seq (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  // Start from the register bank
  input  wire logic                start_in,
  input  wire logic                write_in,
  input  wire logic [5:0]          addr_in,
  input  wire logic [31:0]         wdata_in,
  // Status to the register bank
  output logic                     busy_out,
  output logic                     done_out,
  output logic [31:0]              rdata_out,
  // EEPROM controller side
  output bcr_pkg::bcr_ee_req_s     ee_req_out,
  input  wire logic                ee_done_in,
  input  wire logic [31:0]         ee_rdata_in
);

  typedef enum logic {BCR_SEQ_IDLE, BCR_SEQ_BUSY} bcr_seq_e;

  bcr_seq_e              state_reg;
  bcr_seq_e              state_next;
  bcr_pkg::bcr_ee_req_s  req_reg;
  logic                  done_reg;
  logic [31:0]           rdata_reg;

  wire logic [8:0] ee_addr = {1'b0, addr_in, 2'b00} + `BCR_PI_EE_OFFSET;
  wire logic       finish  = (state_reg == BCR_SEQ_BUSY) && ee_done_in;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BCR_SEQ_IDLE: begin
        if (start_in) begin
          state_next = BCR_SEQ_BUSY;
        end
      end
      BCR_SEQ_BUSY: begin
        if (ee_done_in) begin
          state_next = BCR_SEQ_IDLE;
        end
      end
      default: state_next = BCR_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= BCR_SEQ_IDLE;
      req_reg   <= '0;
      done_reg  <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      done_reg  <= finish;
      if (state_reg == BCR_SEQ_IDLE && start_in) begin
        req_reg <= '{valid: 1'b1, write: write_in, addr: ee_addr, wdata: wdata_in};
      end else if (finish) begin
        req_reg.valid <= 1'b0;
      end
      if (finish && !req_reg.write) begin
        rdata_reg <= ee_rdata_in;
      end
    end
  end

  assign busy_out   = (state_reg == BCR_SEQ_BUSY) || done_reg;
  assign done_out   = done_reg;
  assign rdata_out  = rdata_reg;
  assign ee_req_out = req_reg;

endmodule : bcr_pi_seq

// [design/bcr_cfg_regs.sv]
// Bridge configuration bank C8h..E0h: slot flags, link tuning, product data, window base
//
// What this block does
// - Op flag written 0 starts EEPROM read; flag stays 0, becomes 1 when done.
// - Op flag written 1 starts EEPROM write of data word; flag clears when done.
// - Six-bit access address lives at bits 23:18, read-write, reset zero.
// - Data word carries moved bytes, low byte at address, byte-enable access.
// - EEPROM location is the programmed byte address plus 0x40.
// - Window base bits 31:12 replace upstream addresses falling in the window.
// - Substituted base bits 30:12 follow the window size from the setup register; bit 31 is always substituted.
// - Base bits 11:0 read zero; whole base register resets to zero.
// - Capability header low byte reads fixed identifier 03h.
// - Capability next pointer at bits 15:8 reads F0h.
// - Slot flags at bits 22:16 read-only, reset clear, bits 31:23 zero.
// - Tuning word 0 bits 4:0 are read-write enables resetting to zero.
// - Tuning word 0 bits 7:5 lane negotiation attempts, reset 3h.
// - Tuning word 0 bits 12:8 TS1 count, reset 10h; bits 15:13 zero.
// - Tuning word 0 bits 31:16 L1 entry timer load, reset 0400h.
// - Tuning word 1 holds L0s lifetime 9:0 and L1 lifetime 31:16, reset zero.
// - Tuning word 2 bits 7:0 clock recovery count of FTS sets, reset 54h.
// - Exit latencies at 14:8 reset 2h and 22:16 reset 19h; rest zero.
// - Set size bits make base bits writable; clear size bits keep them read-only.
`timescale 1ns/1ps
`include "bcr_defs.svh"

module bcr_cfg_regs (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  // Configuration access port
  input  wire logic                cfg_req_in,
  input  wire logic                cfg_we_in,
  input  wire logic [7:0]          cfg_addr_in,
  input  wire logic [3:0]          cfg_be_in,
  input  wire logic [31:0]         cfg_wdata_in,
  output logic                     cfg_ack_out,
  output logic [31:0]              cfg_rdata_out,
  // Slot flags from hot-plug logic
  input  bcr_pkg::bcr_slot_s       slot_flags_in,
  // Link tuning values
  output bcr_pkg::bcr_tune_s       tune_out,
  // Upstream window 0 translation
  input  wire logic [18:0]         win0_size_in,
  input  wire logic [31:0]         up_addr_in,
  output logic [31:0]              up_addr_xlat_out,
  output logic [31:0]              win0_base_out,
  // EEPROM controller
  output bcr_pkg::bcr_ee_req_s     ee_req_out,
  input  wire logic                ee_done_in,
  input  wire logic [31:0]         ee_rdata_in
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Byte-lane merge restricted to the writable bits of a register
  function automatic logic [31:0] bcr_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  be,
    input logic [31:0] wmask
  );
    logic [31:0] lanes;
    logic [31:0] m;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    m     = lanes & wmask;
    return (old_val & ~m) | (new_val & m);
  endfunction : bcr_merge

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]          tune0_reg;
  logic [31:0]          tune1_reg;
  logic [31:0]          tune2_reg;
  logic [5:0]           pi_addr_reg;
  logic                 pi_op_reg;
  logic [31:0]          pi_data_reg;
  logic [31:0]          xlat0_reg;
  bcr_pkg::bcr_slot_s   slot_reg;
  logic                 ack_reg;
  logic [31:0]          rdata_reg;
  logic [31:0]          xlat_addr_reg;

  logic [31:0]          tune0_next;
  logic [31:0]          tune1_next;
  logic [31:0]          tune2_next;
  logic [5:0]           pi_addr_next;
  logic                 pi_op_next;
  logic [31:0]          pi_data_next;
  logic [31:0]          xlat0_next;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic wr       = cfg_req_in && cfg_we_in;
  wire logic hit_slot = (cfg_addr_in == `BCR_OFF_SLOT);
  wire logic hit_t0   = (cfg_addr_in == `BCR_OFF_TUNE0);
  wire logic hit_t1   = (cfg_addr_in == `BCR_OFF_TUNE1);
  wire logic hit_t2   = (cfg_addr_in == `BCR_OFF_TUNE2);
  wire logic hit_cmd  = (cfg_addr_in == `BCR_OFF_PI_CMD);
  wire logic hit_data = (cfg_addr_in == `BCR_OFF_PI_DATA);
  wire logic hit_xlat = (cfg_addr_in == `BCR_OFF_XLAT0);

  // ----------------------------------------------------------------
  // Product-data access sequencing
  // ----------------------------------------------------------------
  logic        seq_busy;
  logic        seq_done;
  logic [31:0] seq_rdata;

  // A start while an access is in flight is dropped; flag must toggle first
  wire logic pi_start = wr && hit_cmd && cfg_be_in[3] && !seq_busy;
  wire logic pi_op_wr = cfg_wdata_in[`BCR_PI_OP_BIT];
  // Data to write excludes a same-cycle data-word update: use register
  wire logic pi_rd_done = seq_done && !pi_op_reg;

  bcr_pi_seq u_seq (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .start_in    (pi_start),
    .write_in    (pi_op_wr),
    .addr_in     (pi_addr_next),
    .wdata_in    (pi_data_reg),
    .busy_out    (seq_busy),
    .done_out    (seq_done),
    .rdata_out   (seq_rdata),
    .ee_req_out  (ee_req_out),
    .ee_done_in  (ee_done_in),
    .ee_rdata_in (ee_rdata_in)
  );

  // ----------------------------------------------------------------
  // Window mask
  // ----------------------------------------------------------------
  // Bit 31 is always writable; 30:12 follow the size field
  wire logic [31:0] win0_mask = {1'b1, win0_size_in, `BCR_XLAT0_FIXED};
  wire logic [31:0] win0_base = xlat0_reg & win0_mask;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    tune0_next = tune0_reg;
    tune1_next = tune1_reg;
    tune2_next = tune2_reg;
    if (wr && hit_t0) begin
      tune0_next = bcr_merge(tune0_reg, cfg_wdata_in, cfg_be_in,
                             `BCR_TUNE0_WMASK);
    end
    if (wr && hit_t1) begin
      tune1_next = bcr_merge(tune1_reg, cfg_wdata_in, cfg_be_in,
                             `BCR_TUNE1_WMASK);
    end
    if (wr && hit_t2) begin
      tune2_next = bcr_merge(tune2_reg, cfg_wdata_in, cfg_be_in,
                             `BCR_TUNE2_WMASK);
    end
  end

  always_comb begin
    logic [31:0] cmd_word;
    cmd_word     = bcr_merge({8'h00, pi_addr_reg, 18'h00000}, cfg_wdata_in, cfg_be_in,
                             `BCR_PI_ADDR_WMASK);
    pi_addr_next = pi_addr_reg;
    pi_op_next   = pi_op_reg;
    // Address is frozen while an access runs so the EEPROM sees one location
    if (wr && hit_cmd && !seq_busy) begin
      pi_addr_next = cmd_word[`BCR_PI_ADDR_MSB:`BCR_PI_ADDR_LSB];
    end
    if (pi_start) begin
      pi_op_next = pi_op_wr;
    end else if (seq_done) begin
      pi_op_next = ~pi_op_reg;
    end
  end

  always_comb begin
    pi_data_next = pi_data_reg;
    // Read data from the EEPROM wins over a software write in the same cycle
    if (pi_rd_done) begin
      pi_data_next = seq_rdata;
    end else if (wr && hit_data) begin
      pi_data_next = bcr_merge(pi_data_reg, cfg_wdata_in, cfg_be_in,
                               `BCR_PI_DATA_WMASK);
    end
  end

  always_comb begin
    xlat0_next = xlat0_reg;
    if (wr && hit_xlat) begin
      xlat0_next = bcr_merge(xlat0_reg, cfg_wdata_in, cfg_be_in, win0_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire logic [31:0] rd_slot = {9'h000, slot_reg, 16'h0000};
  wire logic [31:0] rd_cmd  = {pi_op_reg, 7'h00, pi_addr_reg, 2'b00,
                               `BCR_PI_NEXT_PTR, `BCR_PI_CAP_ID};
  wire logic [31:0] rd_mux  =
      hit_slot ? rd_slot     :
      hit_t0   ? tune0_reg   :
      hit_t1   ? tune1_reg   :
      hit_t2   ? tune2_reg   :
      hit_cmd  ? rd_cmd      :
      hit_data ? pi_data_reg :
      hit_xlat ? win0_base   :
                 32'h0000_0000;

  // ----------------------------------------------------------------
  // Translation
  // ----------------------------------------------------------------
  wire logic [31:0] xlat_addr = (win0_base & win0_mask) | (up_addr_in & ~win0_mask);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tune0_reg <= `BCR_TUNE0_RST;
      tune1_reg <= `BCR_TUNE1_RST;
      tune2_reg <= `BCR_TUNE2_RST;
    end else begin
      tune0_reg <= tune0_next;
      tune1_reg <= tune1_next;
      tune2_reg <= tune2_next;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pi_addr_reg <= `BCR_PI_ADDR_RST;
      pi_op_reg   <= 1'b0;
      pi_data_reg <= `BCR_PI_DATA_RST;
      xlat0_reg   <= `BCR_XLAT0_RST;
    end else begin
      pi_addr_reg <= pi_addr_next;
      pi_op_reg   <= pi_op_next;
      pi_data_reg <= pi_data_next;
      xlat0_reg   <= xlat0_next;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slot_reg <= '0;
    end else begin
      slot_reg <= slot_flags_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_reg       <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      xlat_addr_reg <= 32'h0000_0000;
    end else begin
      ack_reg       <= cfg_req_in;
      xlat_addr_reg <= xlat_addr;
      if (cfg_req_in && !cfg_we_in) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_ack_out      = ack_reg;
  assign cfg_rdata_out    = rdata_reg;
  assign up_addr_xlat_out = xlat_addr_reg;
  assign win0_base_out    = win0_base;

  assign tune_out.hot_reset_en       = tune0_reg[0];
  assign tune_out.loopback_en        = tune0_reg[1];
  assign tune_out.crosslink_en       = tune0_reg[2];
  assign tune_out.force_config       = tune0_reg[3];
  assign tune_out.debug_sel          = tune0_reg[4];
  assign tune_out.lane_neg_tries     = tune0_reg[7:5];
  assign tune_out.ts1_count          = tune0_reg[12:8];
  assign tune_out.l1_entry_timer     = tune0_reg[31:16];
  assign tune_out.l0s_lifetime       = tune1_reg[9:0];
  assign tune_out.l1_lifetime        = tune1_reg[31:16];
  assign tune_out.clock_recovery_fts = tune2_reg[7:0];
  assign tune_out.l0s_exit_latency   = tune2_reg[14:8];
  assign tune_out.l1_exit_latency    = tune2_reg[22:16];

endmodule : bcr_cfg_regs

// [dv/bcr_cfg_regs_sva.sv]
// Port assertions for the configuration bank
`timescale 1ns/1ps

module bcr_cfg_regs_sva (
  // Clock and reset
  input wire logic             clk_in,
  input wire logic             nrst_in,
  // Configuration access port
  input wire logic             cfg_req_in,
  input wire logic             cfg_we_in,
  input wire logic [7:0]       cfg_addr_in,
  input wire logic [3:0]       cfg_be_in,
  input wire logic [31:0]      cfg_wdata_in,
  input wire logic             cfg_ack_out,
  input wire logic [31:0]      cfg_rdata_out,
  // Tuning, window and EEPROM side
  input bcr_pkg::bcr_tune_s    tune_out,
  input wire logic [18:0]      win0_size_in,
  input wire logic [31:0]      up_addr_in,
  input wire logic [31:0]      up_addr_xlat_out,
  input wire logic [31:0]      win0_base_out,
  input bcr_pkg::bcr_ee_req_s  ee_req_out,
  input wire logic             ee_done_in
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic        live_reg;
  logic        vld_d_reg;
  logic [31:0] win_mask;
  logic        rd_req;
  logic        pi_start;
  assign win_mask = {1'b1, win0_size_in, 12'h000};
  assign rd_req   = cfg_req_in && !cfg_we_in;
  assign pi_start = cfg_req_in && cfg_we_in && cfg_addr_in == 8'hD8 && cfg_be_in[3];

  // Skip release edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      live_reg  <= 1'b0;
      vld_d_reg <= 1'b0;
    end else begin
      live_reg  <= 1'b1;
      vld_d_reg <= ee_req_out.valid;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in || !live_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ack_follows_req_a: assert property (1'b1 |=> cfg_ack_out == $past(cfg_req_in))
    else $error("ack late");
  cap_header_a: assert property (rd_req && cfg_addr_in == 8'hD8 |=>
    cfg_rdata_out[15:0] == 16'hF003 && cfg_rdata_out[30:24] == 7'h00 && !cfg_rdata_out[17])
    else $error("cap header");
  slot_rsvd_a: assert property (rd_req && cfg_addr_in == 8'hC8 |=>
    cfg_rdata_out[31:23] == 9'h000 && cfg_rdata_out[15:0] == 16'h0000)
    else $error("slot rsvd");
  tune_rsvd_a: assert property (rd_req && cfg_addr_in == 8'hCC |=>
    cfg_rdata_out[15:13] == 3'h0) else $error("tune0 rsvd");
  lifetime_rsvd_a: assert property (rd_req && cfg_addr_in == 8'hD0 |=>
    cfg_rdata_out[15:10] == 6'h00) else $error("tune1 rsvd");
  latency_rsvd_a: assert property (rd_req && cfg_addr_in == 8'hD4 |=>
    cfg_rdata_out[31:23] == 9'h000 && !cfg_rdata_out[15])
    else $error("tune2 rsvd");
  base_low_a: assert property (rd_req && cfg_addr_in == 8'hE0 |=>
    cfg_rdata_out[11:0] == 12'h000) else $error("base low");
  lifetime_out_a: assert property (cfg_req_in && cfg_we_in && cfg_addr_in == 8'hD0 &&
    cfg_be_in == 4'hF |=> {tune_out.l1_lifetime, 6'h00, tune_out.l0s_lifetime} ==
    ($past(cfg_wdata_in) & 32'hFFFF_03FF)) else $error("lifetimes");
  pi_start_a: assert property (pi_start && !ee_req_out.valid && !vld_d_reg |=>
    ee_req_out.valid && ee_req_out.write == $past(cfg_wdata_in[31]) && (!$past(cfg_be_in[2])
    || ee_req_out.addr == {1'b0, $past(cfg_wdata_in[23:18]), 2'b00} + 9'h040))
    else $error("bad start");
  pi_hold_a: assert property (ee_req_out.valid && !ee_done_in |=>
    ee_req_out.valid && $stable(ee_req_out.addr) && $stable(ee_req_out.write))
    else $error("req changed");
  pi_done_a: assert property (ee_req_out.valid && ee_done_in |=> !ee_req_out.valid)
    else $error("req kept");
  xlat_a: assert property (1'b1 |=> up_addr_xlat_out == ($past(win0_base_out) |
    ($past(up_addr_in) & ~$past(win_mask)))) else $error("xlat addr");
  base_mask_a: assert property ((win0_base_out & ~win_mask) == 32'h0000_0000)
    else $error("base mask");
endmodule : bcr_cfg_regs_sva

bind bcr_cfg_regs bcr_cfg_regs_sva u_bcr_cfg_regs_sva (
  .clk_in(clk_in), .nrst_in(nrst_in), .cfg_req_in(cfg_req_in), .cfg_we_in(cfg_we_in),
  .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
  .cfg_ack_out(cfg_ack_out), .cfg_rdata_out(cfg_rdata_out), .tune_out(tune_out),
  .win0_size_in(win0_size_in), .up_addr_in(up_addr_in), .up_addr_xlat_out(up_addr_xlat_out),
  .win0_base_out(win0_base_out), .ee_req_out(ee_req_out), .ee_done_in(ee_done_in)
);

// [dv/bcr_ee_model.sv]
// Behavioural EEPROM controller with a settable answer delay
`timescale 1ns/1ps

module bcr_ee_model (
  // Clock and reset
  input wire logic             clk_in,
  input wire logic             nrst_in,
  // Request from the bank and answer to it
  input bcr_pkg::bcr_ee_req_s  req_in,
  input wire logic [3:0]       delay_in,
  output logic                 done_out,
  output logic [31:0]          rdata_out
);
  logic [7:0] mem [0:511];
  logic [3:0] cnt_reg;
  logic [8:0] a;
  assign a = req_in.addr;

  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end

  // Data toggles outside answers
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg   <= 4'h0;
      done_out  <= 1'b0;
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= ~rdata_out;
      done_out  <= 1'b0;
      if (!req_in.valid || done_out) begin
        cnt_reg <= 4'h0;
      end else if (cnt_reg == delay_in) begin
        done_out <= 1'b1;
        if (req_in.write) begin
          {mem[a+9'd3], mem[a+9'd2], mem[a+9'd1], mem[a]} <= req_in.wdata;
        end else begin
          rdata_out <= {mem[a+9'd3], mem[a+9'd2], mem[a+9'd1], mem[a]};
        end
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule : bcr_ee_model

// [dv/test_bcr_cfg_regs.sv]
// Self-checking bench for the configuration bank
`timescale 1ns/1ps

module test_bcr_cfg_regs;
  logic                 clk_in = 1'b0;
  logic                 nrst_in = 1'b0;
  logic                 cfg_req_in = 1'b0;
  logic                 cfg_we_in = 1'b0;
  logic [7:0]           cfg_addr_in = 8'h00;
  logic [3:0]           cfg_be_in = 4'h0;
  logic [31:0]          cfg_wdata_in = 32'h0;
  logic                 cfg_ack_out;
  logic [31:0]          cfg_rdata_out;
  bcr_pkg::bcr_slot_s   slot_flags_in = '0;
  bcr_pkg::bcr_tune_s   tune_out;
  logic [18:0]          win0_size_in = '0;
  logic [31:0]          up_addr_in = '0;
  logic [31:0]          up_addr_xlat_out;
  logic [31:0]          win0_base_out;
  bcr_pkg::bcr_ee_req_s ee_req_out;
  logic                 ee_done_in;
  logic [31:0]          ee_rdata_in;
  logic [3:0]           ee_delay = 4'h0;
  int                   fail_count = 0;
  int                   checks = 0;
  int                   k;
  logic [31:0]          rd;
  logic [31:0]          d;
  logic [3:0]           be;
  logic [31:0]          shadow [3];
  logic [31:0]          wm [3] = '{32'hFFFF_1FFF, 32'hFFFF_03FF, 32'h007F_7FFF};
  logic [5:0]           al [4] = '{6'h00, 6'h15, 6'h2A, 6'h3F};
  logic [7:0]           ra [8] = '{8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hD8, 8'hDC, 8'hE0, 8'hE4};
  logic [31:0]          rv [8] = '{32'h0, 32'h0400_1060, 32'h0, 32'h0019_0254, 32'h0000_F003,
                                   32'h0, 32'h0, 32'h0};

  bcr_cfg_regs u_bcr_cfg_regs (
    .clk_in(clk_in), .nrst_in(nrst_in), .cfg_req_in(cfg_req_in), .cfg_we_in(cfg_we_in),
    .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_ack_out(cfg_ack_out), .cfg_rdata_out(cfg_rdata_out), .slot_flags_in(slot_flags_in),
    .tune_out(tune_out), .win0_size_in(win0_size_in), .up_addr_in(up_addr_in),
    .up_addr_xlat_out(up_addr_xlat_out), .win0_base_out(win0_base_out),
    .ee_req_out(ee_req_out), .ee_done_in(ee_done_in), .ee_rdata_in(ee_rdata_in)
  );
  bcr_ee_model u_bcr_ee_model (
    .clk_in(clk_in), .nrst_in(nrst_in), .req_in(ee_req_out), .delay_in(ee_delay),
    .done_out(ee_done_in), .rdata_out(ee_rdata_in)
  );

  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) up_addr_in <= $urandom();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cfg(input logic we, input logic [7:0] addr, input logic [3:0] bex,
                     input logic [31:0] data);
    @(posedge clk_in);
    cfg_req_in   <= 1'b1;
    cfg_we_in    <= we;
    cfg_addr_in  <= addr;
    cfg_be_in    <= bex;
    cfg_wdata_in <= data;
    @(posedge clk_in);
    cfg_req_in <= 1'b0;
    @(negedge clk_in);
    chk("ack", 32'h1, {31'h0, cfg_ack_out});
    rd = cfg_rdata_out;
  endtask : cfg

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] b, input logic [31:0] m);
    logic [31:0] bm;
    bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & m;
    return (o & ~bm) | (n & bm);
  endfunction : merge

  // Preset EEPROM word
  function automatic logic [31:0] ee_word(input logic [5:0] a);
    logic [7:0] b;
    b = {a, 2'b00} + 8'h40;
    return {b + 8'h3, b + 8'h2, b + 8'h1, b} ^ {4{8'h5A}};
  endfunction : ee_word

  // Start, refused restart, poll flag
  task automatic pi_op(input logic op, input logic [5:0] a);
    ee_delay <= 4'($urandom_range(7));
    cfg(1'b1, 8'hD8, 4'hC, {op, 7'h00, a, 18'h0});
    cfg(1'b1, 8'hD8, 4'hC, {~op, 7'h00, ~a, 18'h0});
    rd = {op, 31'h0};
    for (int n = 0; n < 40 && rd[31] !== ~op; n++) begin
      cfg(1'b0, 8'hD8, 4'h0, 32'h0);
    end
    chk("op flag", {~op, 7'h00, a, 2'b00, 16'hF003}, rd);
  endtask : pi_op

  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h2311_0571));
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    foreach (ra[i]) begin
      cfg(1'b0, ra[i], 4'h0, 32'h0);
      chk("reset value", rv[i], rd);
    end
    shadow = '{32'h0400_1060, 32'h0, 32'h0019_0254};
    repeat (30) begin
      k = $urandom_range(2);
      d = $urandom();
      be = 4'($urandom()) | {4{d[0]}};
      cfg(1'b1, 8'hCC + 8'(k * 4), be, d);
      shadow[k] = merge(shadow[k], d, be, wm[k]);
      cfg(1'b0, 8'hCC + 8'(k * 4), 4'h0, 32'h0);
      chk("tuning word", shadow[k], rd);
    end
    chk("tuning out", shadow[0], {tune_out.l1_entry_timer, 3'h0, tune_out.ts1_count,
        tune_out.lane_neg_tries, tune_out.debug_sel, tune_out.force_config,
        tune_out.crosslink_en, tune_out.loopback_en, tune_out.hot_reset_en});
    repeat (4) begin
      @(posedge clk_in);
      slot_flags_in <= 7'($urandom());
      cfg(1'b1, 8'hC8, 4'hF, 32'hFFFF_FFFF);
      cfg(1'b0, 8'hC8, 4'h0, 32'h0);
      chk("slot flags", {9'h0, slot_flags_in, 16'h0}, rd);
    end
    repeat (8) begin
      @(posedge clk_in);
      win0_size_in <= 19'($urandom());
      d = $urandom();
      cfg(1'b1, 8'hE0, 4'hF, d);
      cfg(1'b0, 8'hE0, 4'h0, 32'h0);
      chk("window base", d & {1'b1, win0_size_in, 12'h000}, rd);
      chk("base out", rd, win0_base_out);
    end
    foreach (al[i]) begin
      d = $urandom();
      pi_op(1'b0, al[i]);
      cfg(1'b0, 8'hDC, 4'h0, 32'h0);
      chk("read word", ee_word(al[i]), rd);
      cfg(1'b1, 8'hDC, 4'hF, d);
      pi_op(1'b1, al[i]);
      cfg(1'b1, 8'hDC, 4'hF, 32'h0);
      pi_op(1'b0, al[i]);
      cfg(1'b0, 8'hDC, 4'h0, 32'h0);
      chk("written word", d, rd);
    end
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    cfg(1'b0, 8'hCC, 4'h0, 32'h0);
    chk("second reset", 32'h0400_1060, rd);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    summarize();
  end
endmodule : test_bcr_cfg_regs
